// ===== core/rd_burst_pkg.sv
// Shared constants and types for the read burst block.
// How it works
// - Auto precharge closes row; otherwise row stays.
// - First data appears AL plus CL clocks later.
// - Later beats follow on every clock edge.
// - Strobe low, complement high before first data.
// - Strobes float while neither read data nor preamble.
// - Strobe held low half clock after last edge.
// - Data lines released when the burst ends.
// - BL8 reads tCCD apart give seamless data.
// - Chopped reads tCCD apart leave data gap.
// - A started burst always runs to completion.
// - Repeated precharge restarts the precharge period.
// - Address bit ten high selects auto precharge.
// - Auto precharge fires AL plus tRTP later.
// - Auto precharge waits for tRAS and tRTP.
// - Precharge period starts at actual precharge.
// - Auto precharge never within four clocks of prefetch.
// - Fixed eight or on-the-fly with A12 gives BL8.
// - Burst field binary 10 forces chop.
// - On-the-fly with A12 low chops burst.
package rd_burst_pkg;

  localparam int TW = 6;

  // Register byte addresses.
  localparam logic [7:0] ADDR_MODE    = 8'h00;
  localparam logic [7:0] ADDR_TIMING  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_RDCOUNT = 8'h0C;

  // Mode register fields.
  localparam int MODE_AL_LSB = 0;
  localparam int MODE_CL_LSB = 8;
  localparam int MODE_BL_LSB = 16;

  // Timing register fields, in link clock cycles.
  localparam int TIM_RTP_LSB = 0;
  localparam int TIM_RAS_LSB = 8;
  localparam int TIM_RP_LSB  = 16;

  // Status register fields.
  localparam int STAT_OPEN_LSB = 0;
  localparam int STAT_PRE_LSB  = 8;
  localparam int STAT_BUSY_BIT = 16;

  // Reset values.
  localparam logic [TW-1:0] RST_AL   = 6'h00;
  localparam logic [TW-1:0] RST_CL   = 6'h05;
  localparam logic [1:0]    RST_BL   = 2'h0;
  localparam logic [TW-1:0] RST_TRTP = 6'h04;
  localparam logic [TW-1:0] RST_TRAS = 6'h0F;
  localparam logic [TW-1:0] RST_TRP  = 6'h05;

  // Burst length field encodings.
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // Address bit positions with command meaning.
  localparam int AP_BIT  = 10;
  localparam int OTF_BIT = 12;

  // Last beat index of a full and a chopped burst.
  localparam logic [2:0] LAST_BL8 = 3'h7;
  localparam logic [2:0] LAST_BC4 = 3'h3;

  // Least clocks from a read (after AL) to internal precharge.
  localparam logic [TW-1:0] MIN_RD_TO_PRE = 6'h04;

  // Command pin encodings {ras_n, cas_n, we_n} with chip select low.
  localparam logic [2:0] CMD_READ = 3'h5;
  localparam logic [2:0] CMD_ACT  = 3'h3;
  localparam logic [2:0] CMD_PRE  = 3'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PRE  = 2'b01,
    ST_DATA = 2'b10
  } burst_st_t;

  typedef struct packed {
    logic       valid;
    logic       bc4;
    logic [2:0] bank;
    logic [9:0] col;
  } rd_ent_t;

endpackage

// ===== core/bank_ctl_if.sv
// Command events and timing settings passed to the bank timers.
interface bank_ctl_if;
  logic                        ck_rise;
  logic                        act;
  logic                        pre;
  logic                        pre_all;
  logic                        rd_ap;
  logic [2:0]                  ba;
  logic [rd_burst_pkg::TW-1:0] al;
  logic [rd_burst_pkg::TW-1:0] trtp;
  logic [rd_burst_pkg::TW-1:0] tras;
  logic [rd_burst_pkg::TW-1:0] trp;

  modport ctl  (output ck_rise, act, pre, pre_all, rd_ap, ba,
                output al, trtp, tras, trp);
  modport bank (input  ck_rise, act, pre, pre_all, rd_ap, ba,
                input  al, trtp, tras, trp);
endinterface

// ===== core/bank_timer.sv
// Row state and precharge timing of one bank.
module bank_timer #(
  parameter logic [2:0] BANK = 3'h0
) (
  // Clock and reset.
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Commands and settings.
  bank_ctl_if.bank   bus,
  // State.
  output logic       row_open,
  output logic       precharging
);

  localparam int CW = rd_burst_pkg::TW + 1;

  logic [CW-1:0]                 ras_cnt;
  logic [CW-1:0]                 ap_cnt;
  logic                          ap_pend;
  logic [rd_burst_pkg::TW-1:0]   trp_cnt;
  logic                          hit;
  logic                          ap_fire;
  logic                          pre_now;
  logic [rd_burst_pkg::TW-1:0]   rtp_eff;

  assign hit = bus.ba == BANK;
  assign rtp_eff = (bus.trtp < rd_burst_pkg::MIN_RD_TO_PRE) ?
                   rd_burst_pkg::MIN_RD_TO_PRE : bus.trtp;
  assign ap_fire = ap_pend && ap_cnt == '0 &&
                   ras_cnt >= {1'b0, bus.tras};
  assign pre_now = bus.ck_rise &&
                   ((bus.pre && (hit || bus.pre_all)) || ap_fire);
  assign precharging = trp_cnt != '0;

  // Time since the row was opened, saturating.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ras_cnt <= '0;
    end else if (bus.ck_rise) begin
      if (bus.act && hit) begin
        ras_cnt <= CW'(1'b1);
      end else if (ras_cnt != '1) begin
        ras_cnt <= ras_cnt + 1'b1;
      end
    end
  end

  // Pending auto precharge countdown.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ap_pend <= 1'b0;
      ap_cnt  <= '0;
    end else if (bus.ck_rise) begin
      if (bus.rd_ap && hit) begin
        ap_pend <= 1'b1;
        ap_cnt  <= {1'b0, bus.al} + {1'b0, rtp_eff} - 1'b1;
      end else if (ap_fire) begin
        ap_pend <= 1'b0;
      end else if (ap_pend && ap_cnt != '0) begin
        ap_cnt <= ap_cnt - 1'b1;
      end
    end
  end

  // Row open flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_open <= 1'b0;
    end else if (pre_now) begin
      row_open <= 1'b0;
    end else if (bus.ck_rise && bus.act && hit) begin
      row_open <= 1'b1;
    end
  end

  // Precharge period, restarted by every precharge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trp_cnt <= '0;
    end else if (pre_now) begin
      trp_cnt <= bus.trp;
    end else if (bus.ck_rise && trp_cnt != '0) begin
      trp_cnt <= trp_cnt - 1'b1;
    end
  end

endmodule // bank_timer

// ===== core/sdram_read_burst_control.sv
// Read burst datapath, strobe generation and register file.
//
// Chosen here: the APB slave port and the register addresses.
module sdram_read_burst_control #(
  parameter int NUM_BANKS = 8,
  parameter int DQ_W      = 8,
  parameter int PIPE_D    = 32
) (
  // Clock and reset.
  input  wire logic            pclk,
  input  wire logic            presetn,
  // APB slave.
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Memory command pins.
  input  wire logic            ck,
  input  wire logic            cs_n,
  input  wire logic            ras_n,
  input  wire logic            cas_n,
  input  wire logic            we_n,
  input  wire logic [2:0]      ba,
  input  wire logic [13:0]     addr,
  // Data pins.
  input  wire logic [DQ_W-1:0] dq_in,
  output logic      [DQ_W-1:0] dq_out,
  output logic                 dq_oe_n,
  // Strobe pins.
  input  wire logic            dqs_in,
  output logic                 dqs_out,
  output logic                 dqs_oe_n,
  input  wire logic            dqs_n_in,
  output logic                 dqs_n_out,
  output logic                 dqs_n_oe_n
);

  localparam int TW = rd_burst_pkg::TW;
  localparam int PW = 21;

  bank_ctl_if bctl ();

  // Settings.
  logic [TW-1:0] al;
  logic [TW-1:0] cl;
  logic [1:0]    bl_mode;
  logic [TW-1:0] trtp;
  logic [TW-1:0] tras;
  logic [TW-1:0] trp;

  // Pin synchronisers.
  logic [1:0]    ck_sync;
  logic          ck_prev;
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic          ck_rise;
  logic          ck_fall;

  // Command decode.
  logic [2:0]    c_ba;
  logic [13:0]   c_addr;
  logic          c_sel;
  logic [2:0]    c_op;
  logic          is_read;
  logic          is_act;
  logic          is_pre;
  logic          rd_bc4;

  // Read pipeline and burst state.
  rd_burst_pkg::rd_ent_t pipe [PIPE_D];
  rd_burst_pkg::rd_ent_t start_ent;
  rd_burst_pkg::rd_ent_t pre_ent;
  rd_burst_pkg::rd_ent_t cur;
  rd_burst_pkg::rd_ent_t next_cur;
  rd_burst_pkg::burst_st_t state;
  rd_burst_pkg::burst_st_t next_state;
  logic [2:0]    beat;
  logic [2:0]    next_beat;
  logic [2:0]    last_beat;
  logic          done;
  logic [TW:0]   rl;
  logic [15:0]   rd_count;

  // Bank status.
  logic [NUM_BANKS-1:0] row_open;
  logic [NUM_BANKS-1:0] precharging;

  // APB.
  logic          wr_en;
  logic          rd_setup;
  logic          addr_ok;
  logic [31:0]   next_prdata;

  // Two-stage synchronisers for the link clock and command pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_sync <= 2'h0;
      ck_prev <= 1'b0;
      pin_s1  <= '1;
      pin_s2  <= '1;
    end else begin
      ck_sync <= {ck_sync[0], ck};
      ck_prev <= ck_sync[1];
      pin_s1  <= {cs_n, ras_n, cas_n, we_n, ba, addr};
      pin_s2  <= pin_s1;
    end
  end

  assign ck_rise = ck_sync[1] & ~ck_prev;
  assign ck_fall = ~ck_sync[1] & ck_prev;

  assign c_sel  = ~pin_s2[PW-1];
  assign c_op   = pin_s2[PW-2:PW-4];
  assign c_ba   = pin_s2[16:14];
  assign c_addr = pin_s2[13:0];

  assign is_read = ck_rise && c_sel && c_op == rd_burst_pkg::CMD_READ;
  assign is_act  = c_sel && c_op == rd_burst_pkg::CMD_ACT;
  assign is_pre  = c_sel && c_op == rd_burst_pkg::CMD_PRE;

  // Burst length per command.
  assign rd_bc4 = (bl_mode == rd_burst_pkg::BL_FIXED4) ||
                  (bl_mode == rd_burst_pkg::BL_OTF &&
                   !c_addr[rd_burst_pkg::OTF_BIT]);

  // Bank timer controls.
  assign bctl.ck_rise = ck_rise;
  assign bctl.act     = is_act;
  assign bctl.pre     = is_pre;
  assign bctl.pre_all = c_addr[rd_burst_pkg::AP_BIT];
  assign bctl.rd_ap   = c_sel && c_op == rd_burst_pkg::CMD_READ &&
                        c_addr[rd_burst_pkg::AP_BIT];
  assign bctl.ba      = c_ba;
  assign bctl.al      = al;
  assign bctl.trtp    = trtp;
  assign bctl.tras    = tras;
  assign bctl.trp     = trp;

  for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
    bank_timer #(
      .BANK (3'(g))
    ) u_bank (
      .pclk        (pclk),
      .presetn     (presetn),
      .bus         (bctl.bank),
      .row_open    (row_open[g]),
      .precharging (precharging[g])
    );
  end

  // Read pipeline, one stage per link clock cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PIPE_D; i++) begin
        pipe[i] <= '0;
      end
    end else if (ck_rise) begin
      pipe[0] <= '{valid: is_read, bc4: rd_bc4, bank: c_ba,
                   col: c_addr[9:0]};
      for (int i = 1; i < PIPE_D; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end

  // Taps one clock before and at the read latency.
  assign rl = {1'b0, al} + {1'b0, cl};
  always_comb begin
    start_ent = '0;
    pre_ent   = '0;
    if (rl >= (TW+1)'(2) && rl <= (TW+1)'(PIPE_D)) begin
      start_ent = pipe[int'(rl) - 1];
      pre_ent   = pipe[int'(rl) - 2];
    end
  end

  assign last_beat = cur.bc4 ? rd_burst_pkg::LAST_BC4
                             : rd_burst_pkg::LAST_BL8;
  assign done = state != rd_burst_pkg::ST_DATA || beat == last_beat;

  // Burst sequencing.
  always_comb begin
    next_state = state;
    next_beat  = beat;
    next_cur   = cur;
    if (ck_rise && start_ent.valid && done) begin
      next_state = rd_burst_pkg::ST_DATA;
      next_beat  = 3'h0;
      next_cur   = start_ent;
    end else if ((ck_rise || ck_fall) && !done) begin
      next_beat = beat + 3'h1;
    end else if (ck_rise && done) begin
      next_state = pre_ent.valid ? rd_burst_pkg::ST_PRE
                                 : rd_burst_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rd_burst_pkg::ST_IDLE;
      beat  <= 3'h0;
      cur   <= '0;
    end else begin
      state <= next_state;
      beat  <= next_beat;
      cur   <= next_cur;
    end
  end

  // Burst order: low two bits wrap, bit two flips in the second half.
  function automatic logic [DQ_W-1:0] beat_data(
    input rd_burst_pkg::rd_ent_t e,
    input logic [2:0]            b
  );
    logic [9:0] c;
    c = {e.col[9:3], e.col[2] ^ b[2], e.col[1:0] + b[1:0]};
    return DQ_W'(c) ^ DQ_W'({e.bank, 5'h00});
  endfunction

  // Registered pin drive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_out     <= '0;
      dq_oe_n    <= 1'b1;
      dqs_out    <= 1'b0;
      dqs_n_out  <= 1'b1;
      dqs_oe_n   <= 1'b1;
      dqs_n_oe_n <= 1'b1;
    end else begin
      dq_out     <= beat_data(next_cur, next_beat);
      dq_oe_n    <= next_state != rd_burst_pkg::ST_DATA;
      dqs_out    <= next_state == rd_burst_pkg::ST_DATA &&
                    !next_beat[0];
      dqs_n_out  <= !(next_state == rd_burst_pkg::ST_DATA &&
                      !next_beat[0]);
      dqs_oe_n   <= next_state == rd_burst_pkg::ST_IDLE;
      dqs_n_oe_n <= next_state == rd_burst_pkg::ST_IDLE;
    end
  end

  // Count of accepted reads.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_count <= 16'h0000;
    end else if (is_read) begin
      rd_count <= rd_count + 16'h0001;
    end
  end

  // APB slave with no wait states.
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok  = paddr == rd_burst_pkg::ADDR_MODE ||
                    paddr == rd_burst_pkg::ADDR_TIMING ||
                    paddr == rd_burst_pkg::ADDR_STATUS ||
                    paddr == rd_burst_pkg::ADDR_RDCOUNT;
  assign pslverr  = psel && penable && !addr_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al      <= rd_burst_pkg::RST_AL;
      cl      <= rd_burst_pkg::RST_CL;
      bl_mode <= rd_burst_pkg::RST_BL;
    end else if (wr_en && paddr == rd_burst_pkg::ADDR_MODE) begin
      al      <= pwdata[rd_burst_pkg::MODE_AL_LSB +: TW];
      cl      <= pwdata[rd_burst_pkg::MODE_CL_LSB +: TW];
      bl_mode <= pwdata[rd_burst_pkg::MODE_BL_LSB +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trtp <= rd_burst_pkg::RST_TRTP;
      tras <= rd_burst_pkg::RST_TRAS;
      trp  <= rd_burst_pkg::RST_TRP;
    end else if (wr_en && paddr == rd_burst_pkg::ADDR_TIMING) begin
      trtp <= pwdata[rd_burst_pkg::TIM_RTP_LSB +: TW];
      tras <= pwdata[rd_burst_pkg::TIM_RAS_LSB +: TW];
      trp  <= pwdata[rd_burst_pkg::TIM_RP_LSB +: TW];
    end
  end

  always_comb begin
    next_prdata = 32'h00000000;
    case (paddr)
      rd_burst_pkg::ADDR_MODE: begin
        next_prdata[rd_burst_pkg::MODE_AL_LSB +: TW] = al;
        next_prdata[rd_burst_pkg::MODE_CL_LSB +: TW] = cl;
        next_prdata[rd_burst_pkg::MODE_BL_LSB +: 2]  = bl_mode;
      end
      rd_burst_pkg::ADDR_TIMING: begin
        next_prdata[rd_burst_pkg::TIM_RTP_LSB +: TW] = trtp;
        next_prdata[rd_burst_pkg::TIM_RAS_LSB +: TW] = tras;
        next_prdata[rd_burst_pkg::TIM_RP_LSB +: TW]  = trp;
      end
      rd_burst_pkg::ADDR_STATUS: begin
        next_prdata[rd_burst_pkg::STAT_OPEN_LSB +: NUM_BANKS] = row_open;
        next_prdata[rd_burst_pkg::STAT_PRE_LSB +: NUM_BANKS] =
          precharging;
        next_prdata[rd_burst_pkg::STAT_BUSY_BIT] =
          state != rd_burst_pkg::ST_IDLE;
      end
      rd_burst_pkg::ADDR_RDCOUNT: begin
        next_prdata[15:0] = rd_count;
      end
      default: begin
        next_prdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule // sdram_read_burst_control

// ===== bench/rd_burst_props.sv
// Concurrent checks on the data and strobe pins of the read burst block.
module rd_burst_props (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Data and strobe pins.
  input wire logic dq_oe_n,
  input wire logic dqs_out,
  input wire logic dqs_oe_n,
  input wire logic dqs_n_out,
  input wire logic dqs_n_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] run;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run <= 8'h00;
    else if (dq_oe_n) run <= 8'h00;
    else run <= run + 8'h01;
  end
  a_strobe_pair: assert property (
    !dqs_oe_n |-> dqs_n_out != dqs_out) else $error("strobe not paired");
  a_strobe_float: assert property (
    dqs_oe_n == dqs_n_oe_n) else $error("strobe enables differ");
  a_data_strobed: assert property (
    !dq_oe_n |-> !dqs_oe_n) else $error("data without strobe");
  a_idle_low: assert property (
    dq_oe_n && !dqs_oe_n |-> !dqs_out) else $error("strobe high idle");
  a_preamble_len: assert property (
    $fell(dqs_oe_n) |-> (dq_oe_n && !dqs_out)[*8] ##1 (!dq_oe_n && dqs_out))
    else $error("bad preamble");
  a_beat_len: assert property (
    $rose(dqs_out) && !dqs_oe_n |=> dqs_out[*3] ##1 !dqs_out)
    else $error("bad beat length");
  a_burst_whole: assert property (
    $rose(dq_oe_n) |-> run[3:0] == 4'h0 && run != 8'h00)
    else $error("burst cut short");
  a_post_amble: assert property (
    $rose(dq_oe_n) |-> $past(dqs_out) == 1'b0 && $past(dqs_out, 4) == 1'b0
      && $past(dqs_out, 5) == 1'b1) else $error("bad postamble");
  c_preamble: cover property ($fell(dqs_oe_n));
  c_seamless: cover property ($rose(dq_oe_n) && run == 8'h40);
  c_chop: cover property ($rose(dq_oe_n) && run == 8'h10);
endmodule // rd_burst_props

// ===== bench/ctl_model.sv
// Memory controller model driving the clock and command pins.
module ctl_model (
  // Clock and command pins.
  output logic        ck,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [13:0] addr
);
  timeunit 1ns;
  timeprecision 1ns;
  int rises;
  // Earliest rise at which a PRE and an ACT may reach each bank.
  int pre_ok [8];
  int act_ok [8];
  // Limits in whole clocks, rounded up, for the settings the bench uses.
  int rd_pre_gap = 4;
  int trp_gap    = 5;
  int ap_act_gap = 9;
  initial begin
    ck = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba = 3'h0;
    addr = 14'h0000;
    #137;
    forever #400 ck = ~ck;
  end
  always @(posedge ck) rises++;
  // Drives one command, then idles so that calls are n clocks apart.
  // It issues no WRITE, so write data never meets read data.
  task automatic cmd(input logic [2:0] c, b, input logic [13:0] a,
                     input int n, output int at);
    @(negedge ck);
    while ((c == rd_burst_pkg::CMD_PRE && rises + 1 < pre_ok[b]) ||
           (c == rd_burst_pkg::CMD_ACT && rises + 1 < act_ok[b]))
      @(negedge ck);
    at = rises + 1;
    if (c == rd_burst_pkg::CMD_READ) begin
      pre_ok[b] = at + rd_pre_gap;
      if (a[rd_burst_pkg::AP_BIT]) act_ok[b] = at + ap_act_gap;
    end
    if (c == rd_burst_pkg::CMD_PRE) act_ok[b] = at + trp_gap;
    cs_n <= 1'b0;
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    if (n > 1) begin
      @(negedge ck);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= ~c;
      ba <= ~b;
      addr <= ~a;
      repeat (n - 2) @(negedge ck);
    end
  endtask
endmodule // ctl_model

// ===== bench/sdram_read_burst_control_tb_top.sv
// Top testbench of the read burst block with a behavioural output model.
module sdram_read_burst_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [7:0]  paddr, dq_out;
  logic [31:0] pwdata, prdata, rd;
  logic        ck, cs_n, ras_n, cas_n, we_n, oe_p, dqs_p;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic        dq_oe_n, dqs_out, dqs_oe_n, dqs_n_out, dqs_n_oe_n;
  logic [15:0] r;
  int          err_count, compares, rk, cyc, at, a, nrd;
  int          eb[$], es[$];

  sdram_read_burst_control sdram_read_burst_control_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr,
    .dq_in(dq_oe_n ? ~dq_out : dq_out), .dq_out, .dq_oe_n,
    .dqs_in(dqs_oe_n ? ~dqs_out : dqs_out), .dqs_out, .dqs_oe_n,
    .dqs_n_in(dqs_n_oe_n ? ~dqs_n_out : dqs_n_out), .dqs_n_out,
    .dqs_n_oe_n);
  ctl_model ctl_model_i (.ck, .cs_n, .ras_n, .cas_n, .we_n, .ba, .addr);

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge ck) rk++;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen %h want %h", $time, s, e);
    end
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] exp_byte(input logic [2:0] b,
                                          input logic [9:0] c, input int i);
    logic [9:0] k;
    k = {c[9:3], c[2] ^ i[2], c[1:0] + 2'(i)};
    return k[7:0] ^ {b, 5'h00};
  endfunction
  task automatic apb(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic stat(input int n, input int i, input logic e);
    while (rk < n) @(posedge pclk);
    repeat (3) @(posedge pclk);
    apb(1'b0, rd_burst_pkg::ADDR_STATUS, 32'h0);
    chk(rd[i], e);
  endtask
  task automatic rd_cmd(input logic [2:0] b, input logic ap, a12,
                        input int len, rl);
    logic [9:0] c;
    r = lfsr(r);
    c = r[9:0];
    nrd++;
    ctl_model_i.cmd(rd_burst_pkg::CMD_READ, b, {1'b0, a12, 1'b0, ap, c},
                    4, at);
    for (int i = 0; i < len; i++) begin
      eb.push_back(exp_byte(b, c, i));
      es.push_back(i == 0 ? at + rl : -1);
    end
  endtask

  always @(negedge pclk) begin
    if (dq_oe_n === 1'b0 && (oe_p !== 1'b0 || dqs_out !== dqs_p)) begin
      if (eb.size() == 0) chk(32'h1, 32'h0);
      else begin
        chk(dq_out, eb.pop_front());
        if (es[0] >= 0) chk(rk, es[0]);
        void'(es.pop_front());
      end
    end
    oe_p = dq_oe_n;
    dqs_p = dqs_out;
  end

  initial begin
    r = 16'h000A;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, rd_burst_pkg::ADDR_MODE, 32'h0);
    chk(rd, 32'h00000500);
    apb(1'b0, rd_burst_pkg::ADDR_TIMING, 32'h0);
    chk(rd, 32'h00050F04);
    apb(1'b0, 8'h10, 32'h0);
    chk(se, 1'b1);
    ctl_model_i.cmd(rd_burst_pkg::CMD_ACT, 3'h1, 14'h0000, 1, a);
    rd_cmd(3'h1, 1'b1, 1'b1, 8, 5);
    stat(a + 14, 1, 1'b1);
    stat(a + 15, 1, 1'b0);
    stat(a + 16, 9, 1'b1);
    apb(1'b1, rd_burst_pkg::ADDR_MODE, 32'h00000602);
    apb(1'b1, rd_burst_pkg::ADDR_TIMING, 32'h00050F02);
    ctl_model_i.cmd(rd_burst_pkg::CMD_ACT, 3'h2, 14'h0000, 16, a);
    rd_cmd(3'h2, 1'b0, 1'b0, 8, 8);
    rd_cmd(3'h2, 1'b1, 1'b0, 8, 8);
    stat(a + 25, 2, 1'b1);
    stat(a + 26, 2, 1'b0);
    ctl_model_i.cmd(rd_burst_pkg::CMD_PRE, 3'h2, 14'h0000, 3, at);
    ctl_model_i.cmd(rd_burst_pkg::CMD_PRE, 3'h2, 14'h0000, 2, a);
    stat(a + 4, 10, 1'b1);
    stat(a + 7, 10, 1'b0);
    apb(1'b1, rd_burst_pkg::ADDR_MODE, 32'h00010500);
    ctl_model_i.cmd(rd_burst_pkg::CMD_ACT, 3'h3, 14'h0000, 4, a);
    rd_cmd(3'h3, 1'b0, 1'b1, 8, 5);
    rd_cmd(3'h3, 1'b0, 1'b0, 4, 5);
    rd_cmd(3'h3, 1'b0, 1'b0, 4, 5);
    repeat (80) @(posedge pclk);
    apb(1'b1, rd_burst_pkg::ADDR_MODE, 32'h00020500);
    rd_cmd(3'h3, 1'b0, 1'b1, 4, 5);
    rd_cmd(3'h3, 1'b0, 1'b1, 4, 5);
    repeat (120) @(posedge pclk);
    chk(eb.size(), 0);
    stat(rk, 3, 1'b1);
    apb(1'b0, rd_burst_pkg::ADDR_RDCOUNT, 32'h0);
    chk(rd[15:0], nrd);
    summarize();
  end
endmodule // sdram_read_burst_control_tb_top

bind sdram_read_burst_control rd_burst_props rd_burst_props_i (
  .pclk, .presetn, .dq_oe_n, .dqs_out, .dqs_oe_n, .dqs_n_out, .dqs_n_oe_n);
